// ==== hw/pae_pkg.sv ====
// What this block does
// - Alarm when value leaves threshold range
// - Product input forced absolute both, shutdown
// - Absolute compares fixed high, low, both
// - Deviation thresholds follow live set point
// - Monitor inputs never use deviation type
// - Latched alarm holds until operator reset
// - Unlatched alarm clears by itself
// - Reverse energizes output while no alarm
// - Not silent: horn and flashing indicator
// - Silent mutes horn, hides unlatched indicator
// - Silent still shows latched/shutdown indicator
// - Shutdown alarm stops chamber, holds program
// - Event output follows alarm state
// - Output driven only if configured alarm
// - Side selects which thresholds apply
// - Clear needs return by differential
// - Per-alarm message up to 24 characters
//
// Purpose: shared constants and types of the process alarm evaluator
// Assumes: signed 16-bit process values, one alarm per input
// Notes:   register map lives behind a plain strobe port
package pae_pkg;
    localparam int N_IN      = 4;
    localparam int VW        = 16;
    localparam int MSG_LEN   = 24;
    localparam int CH_IDX_W  = 5;
    localparam int IN_IDX_W  = 2;
    localparam int ADDR_W    = 8;
    // Per input register block: 8 words from base 0x00 + 8*input
    localparam logic [ADDR_W-1:0] A_CFG    = 8'h00;
    localparam logic [ADDR_W-1:0] A_HIGH   = 8'h01;
    localparam logic [ADDR_W-1:0] A_LOW    = 8'h02;
    localparam logic [ADDR_W-1:0] A_DIFF   = 8'h03;
    localparam logic [ADDR_W-1:0] A_STATE  = 8'h04;
    localparam logic [ADDR_W-1:0] A_BLK_SZ = 8'h08;
    localparam logic [ADDR_W-1:0] A_IRQ_ST = 8'h40;
    localparam logic [ADDR_W-1:0] A_IRQ_MK = 8'h41;
    localparam logic [ADDR_W-1:0] A_MSG    = 8'h80;
    // Config field positions
    localparam int F_TYPE_DEV = 0;
    localparam int F_SIDE_LO  = 1;
    localparam int F_LATCH    = 3;
    localparam int F_REVERSE  = 4;
    localparam int F_SILENT   = 5;
    localparam int F_SHUTDOWN = 6;
    localparam int F_OUT_EN   = 7;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [1:0] SIDE_HIGH = 2'h1;
    localparam logic [1:0] SIDE_LOW  = 2'h2;
    localparam logic [1:0] SIDE_BOTH = 2'h3;
    localparam logic [VW-1:0] HIGH_RST = 16'h7fff;
    localparam logic [VW-1:0] LOW_RST  = 16'h8000;
    localparam logic [VW-1:0] DIFF_RST = 16'h0000;
    localparam logic [7:0]    MSG_RST  = 8'h20;
    // Half period of the indicator flash, about half a second at 25 MHz
    localparam int FLASH_DIV = 12500000;

    typedef struct packed {
        logic       out_en;
        logic       shutdown;
        logic       silent;
        logic       reverse;
        logic       latch;
        logic [1:0] side;
        logic       dev;
    } pae_cfg_t;

    typedef struct packed {
        pae_cfg_t          cfg;
        logic signed [VW-1:0] high;
        logic signed [VW-1:0] low;
        logic [VW-1:0]     diff;
    } pae_set_t;

    typedef struct packed {
        logic active;
        logic horn;
        logic icon;
        logic shut;
        logic event_out;
    } pae_res_t;

    function automatic pae_cfg_t pae_cfg_of(input logic [7:0] b);
        pae_cfg_t c;
        c = pae_cfg_t'(b);
        return c;
    endfunction
endpackage

// ==== hw/pae_compare.sv ====
// Purpose: one input's threshold and hysteresis decision
// Assumes: combinational, valid on each sample
// Notes:   returns next active state from current state
`timescale 1ns/1ps
module pae_compare import pae_pkg::*; (
    input  wire logic signed [VW-1:0] i_pv,
    input  wire logic signed [VW-1:0] i_sp,
    input  wire pae_set_t             i_set,
    input  wire logic                 i_active,
    input  wire logic                 i_reset_req,
    output logic                      o_active_nxt,
    output logic                      o_cond
);
    logic signed [VW:0] hi_t;
    logic signed [VW:0] lo_t;
    logic signed [VW:0] pv_x;
    logic signed [VW:0] dif_x;
    logic               use_hi;
    logic               use_lo;
    logic               in_band;

    // Threshold derivation, widened by a bit to avoid overflow
    always_comb begin
        pv_x  = {i_pv[VW-1], i_pv};
        dif_x = {1'b0, i_set.diff};
        if (i_set.cfg.dev) begin
            hi_t = {i_sp[VW-1], i_sp} + {i_set.high[VW-1], i_set.high};
            lo_t = {i_sp[VW-1], i_sp} - {i_set.low[VW-1], i_set.low};
        end else begin
            hi_t = {i_set.high[VW-1], i_set.high};
            lo_t = {i_set.low[VW-1], i_set.low};
        end
        use_hi = i_set.cfg.side[0];
        use_lo = i_set.cfg.side[1];
        o_cond = (use_hi && pv_x > hi_t) || (use_lo && pv_x < lo_t);
        // Clear only once back inside by the differential
        in_band = !(use_hi && pv_x > hi_t - dif_x) &&
                  !(use_lo && pv_x < lo_t + dif_x);
        if (o_cond) begin
            o_active_nxt = 1'b1;
        end else if (!i_active) begin
            o_active_nxt = 1'b0;
        end else if (i_set.cfg.latch) begin
            o_active_nxt = !(i_reset_req && in_band);
        end else begin
            o_active_nxt = !in_band;
        end
    end
endmodule

// ==== hw/pae_annunciate.sv ====
// Purpose: indications and outputs from one alarm state
// Assumes: flash enable from a divider in the top
// Notes:   horn is a sticky request held in the top
`timescale 1ns/1ps
module pae_annunciate import pae_pkg::*; (
    input  wire pae_cfg_t i_cfg,
    input  wire logic     i_active,
    input  wire logic     i_horn,
    output pae_res_t      o_res
);
    always_comb begin
        o_res.active = i_active;
        o_res.horn   = i_horn && !i_cfg.silent;
        // Silent hides only alarms that need no intervention
        o_res.icon   = i_active && (!i_cfg.silent || i_cfg.latch
                                    || i_cfg.shutdown);
        o_res.shut   = i_active && i_cfg.shutdown;
        o_res.event_out = i_cfg.out_en && (i_active ^ i_cfg.reverse);
    end
endmodule

// ==== hw/pae_top.sv ====
// Purpose: per-input process alarm evaluator with register port
// Assumes: samples from same clock domain, operator reset synchronised here
// Notes:   input 0 is the product loop, last input is monitor-only
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module pae_top import pae_pkg::*; (
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_reset_n,
    input  wire logic [N_IN*VW-1:0]   i_pv,
    input  wire logic signed [VW-1:0] i_sp,
    input  wire logic                 i_sample,
    input  wire logic                 i_product_loop,
    input  wire logic                 i_op_reset,
    input  wire logic [ADDR_W-1:0]    i_addr,
    input  wire logic [31:0]          i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic [31:0]               o_rdata,
    output logic [N_IN-1:0]           o_event,
    output logic                      o_horn,
    output logic                      o_icon,
    output logic                      o_shutdown,
    output logic                      o_prog_hold,
    output logic [N_IN-1:0]           o_alarm,
    output logic                      o_irq
);
    localparam int MONITOR_IN = N_IN - 1;

    typedef struct packed {
        logic [N_IN-1:0]   active;
        logic [N_IN-1:0]   horn;
        logic [N_IN-1:0]   irq_st;
        logic [N_IN-1:0]   irq_mk;
        logic [N_IN-1:0]   ev;
        logic [1:0]        rst_sync;
        logic              rst_prev;
        logic [23:0]       flash_cnt;
        logic              flash;
        logic              horn_o;
        logic              icon_o;
        logic              shut_o;
        logic [31:0]       rdata;
    } pae_state_t;

    pae_state_t st_r;
    pae_state_t st_nxt;
    pae_set_t   set_r   [N_IN];
    logic [7:0] msg_r   [N_IN][MSG_LEN];
    pae_set_t   eff     [N_IN];
    logic [N_IN-1:0] act_nxt;
    logic [N_IN-1:0] cond;
    pae_res_t   res     [N_IN];
    logic       op_rst_pulse;

    function automatic logic [IN_IDX_W-1:0] pae_in_of(input logic [ADDR_W-1:0] a);
        return a[IN_IDX_W+2:3];
    endfunction

    // Effective settings: product and monitor overrides
    always_comb begin
        for (int i = 0; i < N_IN; i++) begin
            eff[i] = set_r[i];
            if (i == 0 && i_product_loop) begin
                eff[i].cfg.dev      = 1'b0;
                eff[i].cfg.side     = SIDE_BOTH;
                eff[i].cfg.silent   = 1'b0;
                eff[i].cfg.shutdown = 1'b1;
            end
            if (i == MONITOR_IN) begin
                eff[i].cfg.dev = 1'b0;
            end
        end
    end

    assign op_rst_pulse = st_r.rst_sync[1] && !st_r.rst_prev;

    for (genvar g = 0; g < N_IN; g++) begin : g_in
        pae_compare u_cmp (
            .i_pv        (i_pv[g*VW +: VW]),
            .i_sp        (i_sp),
            .i_set       (eff[g]),
            .i_active    (st_r.active[g]),
            .i_reset_req (op_rst_pulse),
            .o_active_nxt(act_nxt[g]),
            .o_cond      (cond[g])
        );
        pae_annunciate u_ann (
            .i_cfg   (eff[g].cfg),
            .i_active(st_r.active[g]),
            .i_horn  (st_r.horn[g]),
            .o_res   (res[g])
        );
    end

    // Next-state of alarm, indications and register read
    always_comb begin
        logic [IN_IDX_W-1:0] sel;
        logic [ADDR_W-1:0]   off;
        logic                any_horn;
        logic                any_icon;
        logic                any_shut;
        sel = pae_in_of(i_addr);
        off = i_addr & (A_BLK_SZ - 8'h01);
        any_horn = 1'b0;
        any_icon = 1'b0;
        any_shut = 1'b0;
        st_nxt = st_r;
        st_nxt.rst_sync = {st_r.rst_sync[0], i_op_reset};
        st_nxt.rst_prev = st_r.rst_sync[1];
        // Slow flash from one cycle enable
        if (st_r.flash_cnt == 24'(FLASH_DIV - 1)) begin
            st_nxt.flash_cnt = 24'h000000;
            st_nxt.flash = !st_r.flash;
        end else begin
            st_nxt.flash_cnt = st_r.flash_cnt + 24'h000001;
        end
        if (op_rst_pulse) begin
            st_nxt.horn = '0;
        end
        if (i_sample || op_rst_pulse) begin
            st_nxt.active = act_nxt;
        end
        for (int i = 0; i < N_IN; i++) begin
            // New alarm raises horn; set wins over reset
            if (i_sample && act_nxt[i] && !st_r.active[i]) begin
                st_nxt.horn[i] = 1'b1;
                st_nxt.irq_st[i] = 1'b1;
            end
            any_horn = any_horn | res[i].horn;
            any_icon = any_icon | res[i].icon;
            any_shut = any_shut | res[i].shut;
            st_nxt.ev[i] = res[i].event_out;
        end
        st_nxt.horn_o = any_horn;
        st_nxt.icon_o = any_icon && st_r.flash;
        st_nxt.shut_o = any_shut;
        st_nxt.rdata = 32'h00000000;
        if (i_wr && i_addr == A_IRQ_ST) begin
            for (int i = 0; i < N_IN; i++) begin
                if (i_wdata[i] && !(i_sample && act_nxt[i] && !st_r.active[i])) begin
                    st_nxt.irq_st[i] = 1'b0;
                end
            end
        end else if (i_wr && i_addr == A_IRQ_MK) begin
            st_nxt.irq_mk = i_wdata[N_IN-1:0];
        end
        if (i_rd) begin
            if (i_addr < A_IRQ_ST) begin
                if (off == A_CFG) begin
                    st_nxt.rdata = {24'h000000, eff[sel].cfg};
                end else if (off == A_HIGH) begin
                    st_nxt.rdata = {16'h0000, set_r[sel].high};
                end else if (off == A_LOW) begin
                    st_nxt.rdata = {16'h0000, set_r[sel].low};
                end else if (off == A_DIFF) begin
                    st_nxt.rdata = {16'h0000, set_r[sel].diff};
                end else if (off == A_STATE) begin
                    st_nxt.rdata = {30'h00000000, cond[sel], st_r.active[sel]};
                end
            end else if (i_addr == A_IRQ_ST) begin
                st_nxt.rdata = {28'h0000000, st_r.irq_st};
            end else if (i_addr == A_IRQ_MK) begin
                st_nxt.rdata = {28'h0000000, st_r.irq_mk};
            end else if (i_addr >= A_MSG) begin
                // Index widened a bit so a full set of inputs stays reachable
                if ({1'b0, i_addr[6:5]} < 3'(N_IN) && i_addr[4:0] < 5'(MSG_LEN)) begin
                    st_nxt.rdata = {24'h000000, msg_r[i_addr[6:5]][i_addr[4:0]]};
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Settings and message store, written only by software
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < N_IN; i++) begin
                set_r[i] <= '{cfg: pae_cfg_t'(CFG_RST), high: HIGH_RST,
                              low: LOW_RST, diff: DIFF_RST};
                for (int k = 0; k < MSG_LEN; k++) begin
                    msg_r[i][k] <= MSG_RST;
                end
            end
        end else if (i_wr) begin
            if (i_addr < A_IRQ_ST) begin
                if ((i_addr & (A_BLK_SZ - 8'h01)) == A_CFG) begin
                    set_r[pae_in_of(i_addr)].cfg <= pae_cfg_of(i_wdata[7:0]);
                end else if ((i_addr & (A_BLK_SZ - 8'h01)) == A_HIGH) begin
                    set_r[pae_in_of(i_addr)].high <= i_wdata[VW-1:0];
                end else if ((i_addr & (A_BLK_SZ - 8'h01)) == A_LOW) begin
                    set_r[pae_in_of(i_addr)].low <= i_wdata[VW-1:0];
                end else if ((i_addr & (A_BLK_SZ - 8'h01)) == A_DIFF) begin
                    set_r[pae_in_of(i_addr)].diff <= i_wdata[VW-1:0];
                end
            end else if (i_addr >= A_MSG && {1'b0, i_addr[6:5]} < 3'(N_IN)) begin
                if (i_addr[4:0] < 5'(MSG_LEN)) begin
                    msg_r[i_addr[6:5]][i_addr[4:0]] <= i_wdata[7:0];
                end
            end
        end
    end

    assign o_rdata     = st_r.rdata;
    assign o_event     = st_r.ev;
    assign o_horn      = st_r.horn_o;
    assign o_icon      = st_r.icon_o;
    assign o_shutdown  = st_r.shut_o;
    assign o_prog_hold = st_r.shut_o;
    assign o_alarm     = st_r.active;
    assign o_irq       = |(st_r.irq_st & st_r.irq_mk);

    // Hold must track any shutdown-enabled alarm of the previous cycle
    a_shut_follows: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        o_prog_hold == $past(res[0].shut || res[1].shut || res[2].shut || res[3].shut))
        else $error("hold differs from shutdown");
    a_product_shut: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_product_loop && st_r.active[0]) |=> o_shutdown)
        else $error("product alarm did not shut down");
    a_horn_clears: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        op_rst_pulse && !i_sample |=> ##1 !o_horn) else $error("horn not silenced");
    a_sample_update: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_sample |=> st_r.active == $past(act_nxt)) else $error("alarm not updated");
    a_hold_nosample: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        !i_sample && !op_rst_pulse |=> $stable(st_r.active))
        else $error("alarm moved without sample");
    a_cond_raises: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_sample && cond[0] |=> st_r.active[0]) else $error("condition not alarmed");
    a_latch_keeps: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        st_r.active[2] && eff[2].cfg.latch && !op_rst_pulse |=> st_r.active[2])
        else $error("latched alarm dropped");
    a_event_drive: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        !eff[1].cfg.out_en |=> !o_event[1]) else $error("unassigned output driven");
    // No alarm anywhere means a dark indicator, whatever the flash phase
    a_icon_hidden: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        !(|st_r.active) |=> !o_icon) else $error("indicator lit without alarm");
endmodule

// ==== testbench/pae_panel_model.sv ====
// Purpose: operator panel reset button seen by the alarm evaluator
// Assumes: one request pulse per press, same clock as the bench
// Notes:   button held for 8 cycles, long enough for the 2-FF sync
`timescale 1ns/1ps
module pae_panel_model (
    input  wire logic i_clk,
    input  wire logic i_press,
    output logic      o_button
);
    logic [3:0] hold_cnt;

    initial begin
        hold_cnt = 4'h0;
        o_button = 1'b0;
    end

    // A real button bounces; a clean level press keeps the bench exact
    always @(posedge i_clk) begin
        if (i_press) begin
            hold_cnt <= 4'h8;
            o_button <= 1'b1;
        end else if (hold_cnt != 4'h0) begin
            hold_cnt <= hold_cnt - 4'h1;
            o_button <= (hold_cnt != 4'h1);
        end
    end
endmodule

// ==== testbench/pae_top_tb_top.sv ====
// Purpose: self-checking bench of the process alarm evaluator
// Assumes: input 0 product loop, input 3 monitor-only, irq bit per input
// Notes:   icon flash divider too long to observe, only its dark phase is seen
`timescale 1ns/1ps
module pae_top_tb_top;
    import pae_pkg::*;
    logic               clk = 1'b0, rst_n = 1'b0, smp_r = 1'b0, prod = 1'b0;
    logic [N_IN*VW-1:0] pv = '0;
    logic [VW-1:0]      sp = '0;
    logic [ADDR_W-1:0]  addr = '0;
    logic [31:0]        wdata = '0, rdata, d;
    logic               wr = 1'b0, rd_s = 1'b0, press = 1'b0, button;
    logic [N_IN-1:0]    ev, alarm;
    logic               horn, icon, shut, hold, irq;
    int                 n_errors = 0, tests_run = 0;

    // Clock at 25 MHz
    always #20 clk = ~clk;

    pae_panel_model panel_u (.i_clk(clk), .i_press(press), .o_button(button));

    pae_top dut_u (.i_sys_clk(clk), .i_reset_n(rst_n), .i_pv(pv), .i_sp(sp),
        .i_sample(smp_r), .i_product_loop(prod), .i_op_reset(button), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd_s), .o_rdata(rdata), .o_event(ev),
        .o_horn(horn), .o_icon(icon), .o_shutdown(shut), .o_prog_hold(hold),
        .o_alarm(alarm), .o_irq(irq));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= v; end
        @(posedge clk) wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk) begin rd_s <= 1'b1; addr <= a; end
        @(posedge clk) rd_s <= 1'b0;
        #1 v = rdata;
    endtask

    // One sample, then let alarm and outputs settle
    task automatic sample(input int idx, input logic [15:0] v);
        @(posedge clk) begin pv[idx*16 +: 16] <= v; smp_r <= 1'b1; end
        @(posedge clk) smp_r <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic push_reset;
        @(posedge clk) press <= 1'b1;
        @(posedge clk) press <= 1'b0;
        repeat (14) @(posedge clk);
        #1;
    endtask

    task automatic t_abs_high;
        wr_reg(8'h08, 32'h0000_0082);
        wr_reg(8'h09, 32'h0000_0064);
        wr_reg(8'h0a, 32'h0000_0000);
        wr_reg(8'h0b, 32'h0000_000a);
        wr_reg(8'h41, 32'h0000_000f);
        sample(1, 16'h0096);
        chk(alarm[1], 1'b1);
        chk(ev[1], 1'b1);
        chk(horn, 1'b1);
        chk(icon, 1'b0);
        chk(shut, 1'b0);
        chk(irq, 1'b1);
        sample(1, 16'h005f);
        chk(alarm[1], 1'b1);
        sample(1, 16'h005a);
        chk(alarm[1], 1'b0);
        chk(ev[1], 1'b0);
        sample(1, 16'hff00);
        chk(alarm[1], 1'b0);
        chk(horn, 1'b1);
        wr_reg(8'h40, 32'h0000_000f);
        #1 chk(irq, 1'b0);
        push_reset;
        chk(horn, 1'b0);
    endtask

    task automatic t_low_latch_rev;
        wr_reg(8'h10, 32'h0000_009c);
        wr_reg(8'h11, 32'h0000_0064);
        wr_reg(8'h12, 32'h0000_ffce);
        sample(2, 16'h0000);
        chk(ev[2], 1'b1);
        sample(2, 16'hffc4);
        chk(alarm[2], 1'b1);
        chk(ev[2], 1'b0);
        sample(2, 16'h0000);
        chk(alarm[2], 1'b1);
        push_reset;
        chk(alarm[2], 1'b0);
        chk(ev[2], 1'b1);
    endtask

    task automatic t_silent_shut;
        wr_reg(8'h41, 32'h0000_0000);
        wr_reg(8'h08, 32'h0000_0062);
        sample(1, 16'h0096);
        chk(alarm[1], 1'b1);
        chk(ev[1], 1'b0);
        chk(horn, 1'b0);
        chk({shut, hold}, 2'b11);
        chk(irq, 1'b0);
        sample(1, 16'h0000);
        chk({shut, hold}, 2'b00);
    endtask

    task automatic t_deviation;
        wr_reg(8'h08, 32'h0000_0007);
        wr_reg(8'h09, 32'h0000_0014);
        wr_reg(8'h0a, 32'h0000_0014);
        wr_reg(8'h0b, 32'h0000_0000);
        @(posedge clk) sp <= 16'h0032;
        sample(1, 16'h0047);
        chk(alarm[1], 1'b1);
        @(posedge clk) sp <= 16'h003c;
        sample(1, 16'h0047);
        chk(alarm[1], 1'b0);
        sample(1, 16'h0027);
        chk(alarm[1], 1'b1);
        sample(1, 16'h0032);
        chk(alarm[1], 1'b0);
        wr_reg(8'h18, 32'h0000_0007);
        rd_reg(8'h18, d);
        chk(d[7:0], 8'h06);
    endtask

    task automatic t_product;
        @(posedge clk) prod <= 1'b1;
        wr_reg(8'h00, 32'h0000_0020);
        wr_reg(8'h01, 32'h0000_0064);
        wr_reg(8'h02, 32'h0000_0000);
        rd_reg(8'h00, d);
        chk(d[7:0], 8'h46);
        sample(0, 16'h0096);
        chk({alarm[0], shut, horn}, 3'b111);
        sample(0, 16'hfff0);
        chk(alarm[0], 1'b1);
        sample(0, 16'h000a);
        chk(alarm[0], 1'b0);
    endtask

    task automatic t_message;
        rd_reg(8'h80, d);
        chk(d[7:0], 8'h20);
        wr_reg(8'h97, 32'h0000_0041);
        rd_reg(8'h97, d);
        chk(d[7:0], 8'h41);
        rd_reg(8'h7f, d);
        chk(d, 32'h0000_0000);
    endtask

    task automatic final_report;
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_abs_high;
        t_low_latch_rev;
        t_silent_shut;
        t_deviation;
        t_product;
        t_message;
        final_report;
    end

    // Watchdog, far above the under two hundred cycles the tests need
    initial begin
        #400000;
        n_errors++;
        final_report;
    end
endmodule
